// ===== tb/clock_request_pio_control_tb.sv
`include "clkreq_map.svh"
module clock_request_pio_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [11:0] port;
    } row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic        pready, pslverr, sleep, irq, osc_en, err;
    logic [31:0] prdata, rd;
    logic [17:0] lvl, drv, oe;
    logic [17:0] board = '0;
    logic        host_req = 1'b0;
    logic [3:0]  apin0;
    logic [1:0]  apin1;
    logic [5:0]  trim;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    row_t        rows [8] = '{
        '{`OFS_XTAL_TRIM, 32'h0000_003F, 32'h0000_003F, 12'h03F},
        '{`OFS_XTAL_TRIM, 32'h0000_0000, 32'h0000_0000, 12'h000},
        '{`OFS_APIN_SEL,  32'h0000_000B, 32'h0000_000B, 12'h2C0},
        '{`OFS_APIN_SEL,  32'h0000_002A, 32'h0000_002A, 12'hA80},
        '{`OFS_APIN_SEL,  32'h0000_003C, 32'h0000_002A, 12'hA80},
        '{`OFS_APIN_SEL,  32'h0000_001B, 32'h0000_001B, 12'h6C0},
        '{`OFS_INT_MASK,  32'h0007_FFFF, 32'h0007_FFFF, 12'h6C0},
        '{`OFS_XTAL_TRIM, 32'hFFFF_FFC1, 32'h0000_0001, 12'h6C1}};

    always #2.5 clk = ~clk;

    clock_request_pio_control dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_prog_io_line(lvl),
        .o_prog_io_line(drv), .o_prog_io_oe(oe), .o_analogue_io_pin0_sel(apin0),
        .o_analogue_io_pin1_sel(apin1), .o_crystal_trim_code(trim),
        .o_deep_sleep(sleep), .o_irq(irq));

    osc_host_model partner (.i_line_drive(drv), .i_line_oe(oe), .i_board(board),
        .i_host_clk_req(host_req), .o_line_level(lvl), .o_osc_enable(osc_en));

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic test_done();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for ready; the cycle ceiling ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        board[b] <= 1'b1;
        repeat (3) @(posedge clk);
        board[b] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic ctrl(input logic [31:0] d);
        apb(1'b1, `OFS_CLK_CTRL, d);
        repeat (2) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wd);
            apb(1'b0, rows[i].addr, 32'h0000_0000);
            check(rd, rows[i].rd);
            check(32'({apin1, apin0, trim}), 32'(rows[i].port));
        end
        check(32'(oe[2]), 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(32'(trim), 32'h0000_0020);
        check(32'({oe[2], osc_en, irq}), 32'h0000_0002);
        apb(1'b0, 12'h030, 32'h0000_0000);
        check(32'({err, rd[0]}), 32'h0000_0002);
        @(posedge clk);
        board <= 18'h2_A5F0;
        repeat (3) @(posedge clk);
        apb(1'b0, `OFS_LINE_LEVEL, 32'h0000_0000);
        check(rd, 32'h0002_A5F4);
        board <= '0;
        apb(1'b1, `OFS_LINE_DIR, 32'h0003_FFFF);
        apb(1'b1, `OFS_LINE_OUT, 32'h0001_2345);
        repeat (2) @(posedge clk);
        check(32'(oe), 32'h0003_FFFF);
        check(32'(drv), 32'h0001_2345);
        apb(1'b1, `OFS_LINE_DIR, 32'h0000_0000);
        apb(1'b1, `OFS_INT_MASK, 32'h0007_FFFF);
        apb(1'b1, `OFS_IRQ_SEL, 32'h0000_0020);
        pulse(5);
        check(32'(irq), 32'h0000_0001);
        apb(1'b1, `OFS_INT_STATUS, 32'h0000_0020);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, `OFS_INT_MASK, 32'h0000_0000);
        pulse(5);
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        check({rd[31:1], irq}, 32'h0000_0020);
        apb(1'b1, `OFS_INT_STATUS, 32'h0000_0020);
        ctrl(32'h0000_0001);
        check(32'({oe[6], drv[6]}), 32'h0000_0003);
        ctrl(32'h0000_0009);
        check(32'({sleep, oe[6], drv[6]}), 32'h0000_0006);
        ctrl(32'h0000_0003);
        check(32'({oe[2], drv[2]}), 32'h0000_0003);
        ctrl(32'h0000_000B);
        check(32'({oe[2], drv[2]}), 32'h0000_0002);
        ctrl(32'h0000_0009);
        apb(1'b1, `OFS_WAKE_SEL, 32'h0000_0200);
        pulse(9);
        check(32'({sleep, drv[6]}), 32'h0000_0001);
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        check(rd, 32'h0004_0000);
        ctrl(32'h0000_000C);
        check(32'({oe[3], oe[2], drv[2]}), 32'h0000_0002);
        @(posedge clk);
        host_req <= 1'b1;
        @(negedge clk);
        check(32'({drv[2], osc_en}), 32'h0000_0003);
        @(posedge clk);
        host_req <= 1'b0;
        @(negedge clk);
        check(32'({drv[2], osc_en}), 32'h0000_0000);
        ctrl(32'h0000_0004);
        check(32'({drv[2], osc_en}), 32'h0000_0003);
        test_done();
    end
endmodule // clock_request_pio_control_tb

// ===== tb/osc_host_model.sv
// ------------------------------------------------
// Host enable and oscillator enable wire model
// ------------------------------------------------
module osc_host_model (
    input  wire logic [17:0] i_line_drive,   // Device drive values
    input  wire logic [17:0] i_line_oe,      // Device drive enables
    input  wire logic [17:0] i_board,        // Other board sources
    input  wire logic        i_host_clk_req, // Host wants the clock
    output logic      [17:0] o_line_level,   // Resolved pin levels
    output logic             o_osc_enable    // Oscillator enable wire
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb begin
        o_line_level    = i_board;
        o_line_level[2] = 1'b1;           // Pull-up keeps oscillator on
        o_line_level[3] = i_host_clk_req; // Host enable, active high
        for (int i = 0; i < 18; i++) begin
            if (i_line_oe[i]) begin
                o_line_level[i] = i_line_drive[i];
            end
        end
    end

    assign o_osc_enable = o_line_level[2]; // Oscillator runs while high
endmodule // osc_host_model

// ===== verilog/clkreq_map.svh
`ifndef CLKREQ_MAP_SVH
`define CLKREQ_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_LINE_OUT    12'h000
`define OFS_LINE_DIR    12'h004
`define OFS_LINE_LEVEL  12'h008
`define OFS_IRQ_SEL     12'h00C
`define OFS_WAKE_SEL    12'h010
`define OFS_INT_STATUS  12'h014
`define OFS_INT_MASK    12'h018
`define OFS_CLK_CTRL    12'h01C
`define OFS_XTAL_TRIM   12'h020
`define OFS_APIN_SEL    12'h024

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CTRL_REQ_EN     0
`define CTRL_REQ_SEL    1
`define CTRL_OR_EN      2
`define CTRL_SLEEP      3
`define WAKE_BIT        18
`define TRIM_W          6
`define APIN0_W         4
`define APIN1_W         2
`define REQ_LINE_A      6
`define REQ_LINE_B      2
`define HOST_EN_LINE    3

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define TRIM_RST        6'h20
`define APIN0_MAX       4'hB
`define APIN1_MAX       2'h2

`endif

// ===== verilog/clkreq_pkg.sv
package clkreq_pkg;

    // Analogue pin clock codes; pin 1 takes only off, xtal, xtal/2
    typedef enum logic [3:0] {
        APIN_OFF    = 4'b0000,
        APIN_64M    = 4'b0001,
        APIN_48M    = 4'b0010,
        APIN_32M    = 4'b0011,
        APIN_24M    = 4'b0100,
        APIN_16M    = 4'b0101,
        APIN_12M    = 4'b0110,
        APIN_8M     = 4'b0111,
        APIN_6M     = 4'b1000,
        APIN_2M     = 4'b1001,
        APIN_XTAL   = 4'b1010,
        APIN_XTAL_2 = 4'b1011
    } apin_clk_t;

    typedef struct packed {
        logic [17:0] sync1;
        logic [17:0] sync2;
        logic [17:0] prev;
        logic [17:0] out;
        logic [17:0] dir;
        logic [17:0] irq_sel;
        logic [17:0] wake_sel;
        logic [18:0] status;
        logic [18:0] mask;
        logic        req_en;
        logic        req_sel;
        logic        or_en;
        logic        sleep;
        logic        configured;
        logic [5:0]  trim;
        logic [3:0]  apin0;
        logic [1:0]  apin1;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
        logic [17:0] pin_o;
        logic [17:0] pin_oe;
    } state_t;

endpackage

// ===== verilog/clock_request_pio_control.sv
`include "clkreq_map.svh"

// Functional notes
// R1: Eighteen programmable lines, each with its own direction control.
// R2: Any line may raise an interrupt or wake the device from sleep.
// R3: Clock request drives line 6 or line 2, chosen by the select key.
// R4: Clock request is low in deep sleep, high when a clock is needed.
// R5: Host and device clock enables are ORed; either starts the clock.
// R6: OR mode: line 3 is host enable in, line 2 outputs the OR.
// R7: Host raises line 3 high to request the clock; active high.
// R8: Line 2 stays undriven from reset until configured; board pulls it.
// R9: Crystal trim is a six bit code, 0 to 63, 125 fF per step.
// R10: Divided clocks only on analogue pin 0; xtal and xtal/2 on both.
// R11: OR path is combinational so it works with internal clocks stopped.
module clock_request_pio_control #(
    parameter int LINES = 18
) (
    input  wire logic              i_ref_clk,       // 200 MHz clock
    input  wire logic              i_sys_rst,       // Sync reset, high
    input  wire logic              i_psel,          // APB select
    input  wire logic              i_penable,       // APB enable
    input  wire logic              i_pwrite,        // APB write
    input  wire logic [11:0]       i_paddr,         // APB byte address
    input  wire logic [31:0]       i_pwdata,        // APB write data
    output logic                   o_pready,        // APB ready
    output logic      [31:0]       o_prdata,        // APB read data
    output logic                   o_pslverr,       // APB error
    input  wire logic [LINES-1:0]  i_prog_io_line,  // Line pin levels
    output logic      [LINES-1:0]  o_prog_io_line,  // Line pin drive
    output logic      [LINES-1:0]  o_prog_io_oe,    // Line drive enable
    output logic [`APIN0_W-1:0]    o_analogue_io_pin0_sel, // Pin 0 clock
    output logic [`APIN1_W-1:0]    o_analogue_io_pin1_sel, // Pin 1 clock
    output logic [`TRIM_W-1:0]     o_crystal_trim_code,    // Trim code
    output logic                   o_deep_sleep,    // Device asleep
    output logic                   o_irq            // Interrupt level
);

    clkreq_pkg::state_t s_q;
    clkreq_pkg::state_t s_d;

    logic [17:0] rise;
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rdata;
    logic        wake;

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    function automatic logic [32:0] rd_mux(input clkreq_pkg::state_t s,
                                           input logic [11:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        unique case (a)
            `OFS_LINE_OUT:   r = {1'b1, 14'h0, s.out};
            `OFS_LINE_DIR:   r = {1'b1, 14'h0, s.dir};
            `OFS_LINE_LEVEL: r = {1'b1, 14'h0, s.sync2};
            `OFS_IRQ_SEL:    r = {1'b1, 14'h0, s.irq_sel};
            `OFS_WAKE_SEL:   r = {1'b1, 14'h0, s.wake_sel};
            `OFS_INT_STATUS: r = {1'b1, 13'h0, s.status};
            `OFS_INT_MASK:   r = {1'b1, 13'h0, s.mask};
            `OFS_CLK_CTRL:   r = {1'b1, 28'h0, s.sleep, s.or_en,
                                  s.req_sel, s.req_en};
            `OFS_XTAL_TRIM:  r = {1'b1, 26'h0, s.trim};
            `OFS_APIN_SEL:   r = {1'b1, 26'h0, s.apin1, s.apin0};
            default:         r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d   = s_q;
        acc   = i_psel && i_penable && s_q.pready;
        wr    = acc && i_pwrite;
        {hit, rdata} = rd_mux(s_q, i_paddr);
        rise  = s_q.sync2 & ~s_q.prev;
        wake  = s_q.sleep && |(rise & s_q.wake_sel);  // [R2]

        s_d.sync1 = i_prog_io_line;                   // [R1]
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;

        // APB: one wait state, answer from flops
        s_d.pready  = i_psel && i_penable && !s_q.pready;
        s_d.prdata  = 32'h0000_0000;
        s_d.pslverr = 1'b0;
        if (i_psel && i_penable && !s_q.pready) begin
            s_d.pslverr = !hit;
            if (!i_pwrite) begin
                s_d.prdata = rdata;
            end
        end

        if (wr) begin
            unique case (i_paddr)
                `OFS_LINE_OUT: begin
                    s_d.out = i_pwdata[17:0];
                end
                `OFS_LINE_DIR: begin
                    s_d.dir        = i_pwdata[17:0];     // [R1]
                    s_d.configured = 1'b1;               // [R8]
                end
                `OFS_IRQ_SEL: begin
                    s_d.irq_sel = i_pwdata[17:0];        // [R2]
                end
                `OFS_WAKE_SEL: begin
                    s_d.wake_sel = i_pwdata[17:0];       // [R2]
                end
                `OFS_INT_MASK: begin
                    s_d.mask = i_pwdata[18:0];
                end
                `OFS_CLK_CTRL: begin
                    s_d.req_en     = i_pwdata[`CTRL_REQ_EN];   // [R3]
                    s_d.req_sel    = i_pwdata[`CTRL_REQ_SEL];  // [R3]
                    s_d.or_en      = i_pwdata[`CTRL_OR_EN];    // [R6]
                    s_d.sleep      = i_pwdata[`CTRL_SLEEP];
                    s_d.configured = 1'b1;                     // [R8]
                end
                `OFS_XTAL_TRIM: begin
                    s_d.trim = i_pwdata[5:0];                  // [R9]
                end
                `OFS_APIN_SEL: begin
                    // Out-of-range codes leave the selection unchanged
                    if (i_pwdata[3:0] <= `APIN0_MAX) begin     // [R10]
                        s_d.apin0 = i_pwdata[3:0];
                    end
                    if (i_pwdata[5:4] <= `APIN1_MAX) begin     // [R10]
                        s_d.apin1 = i_pwdata[5:4];
                    end
                end
                default: begin
                end
            endcase
        end

        // Wake-up line ends deep sleep
        if (wake) begin
            s_d.sleep = 1'b0;                                  // [R2]
        end

        // Sticky status: write one clears, new event wins
        if (wr && i_paddr == `OFS_INT_STATUS) begin
            s_d.status = s_q.status & ~i_pwdata[18:0];
        end
        s_d.status[17:0]      = s_d.status[17:0] | (rise & s_q.irq_sel); // [R2]
        s_d.status[`WAKE_BIT] = s_d.status[`WAKE_BIT] | wake;
        s_d.irq               = |(s_q.status & s_q.mask);

        // Pin drive
        s_d.pin_o  = s_q.out;
        s_d.pin_oe = s_q.dir;
        if (!s_q.configured) begin
            s_d.pin_oe[`REQ_LINE_B] = 1'b0;                    // [R8]
        end
        if (s_q.req_en) begin
            if (s_q.req_sel) begin
                s_d.pin_o[`REQ_LINE_B]  = !s_q.sleep;          // [R3] [R4]
                s_d.pin_oe[`REQ_LINE_B] = 1'b1;
            end else begin
                s_d.pin_o[`REQ_LINE_A]  = !s_q.sleep;          // [R3] [R4]
                s_d.pin_oe[`REQ_LINE_A] = 1'b1;
            end
        end
        if (s_q.or_en) begin
            s_d.pin_oe[`HOST_EN_LINE] = 1'b0;                  // [R6] [R7]
            s_d.pin_oe[`REQ_LINE_B]   = 1'b1;                  // [R6]
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            s_q      <= '0;
            s_q.trim <= `TRIM_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Host enable in OR mode bypasses the clock so it works while stopped
    always_comb begin
        o_prog_io_line = s_q.pin_o;
        if (s_q.or_en) begin
            o_prog_io_line[`REQ_LINE_B] = i_prog_io_line[`HOST_EN_LINE]
                                          | !s_q.sleep;        // [R5] [R11]
        end
    end

    assign o_prog_io_oe           = s_q.pin_oe;
    assign o_pready               = s_q.pready;
    assign o_prdata               = s_q.prdata;
    assign o_pslverr              = s_q.pslverr;
    assign o_analogue_io_pin0_sel = s_q.apin0;
    assign o_analogue_io_pin1_sel = s_q.apin1;
    assign o_crystal_trim_code    = s_q.trim;
    assign o_deep_sleep           = s_q.sleep;
    assign o_irq                  = s_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_pin_sync_two: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R1]
        !$past(i_sys_rst) && !$past(i_sys_rst, 2)
            |-> s_q.sync2 == $past(i_prog_io_line, 2))
        else $error("line level not synchronised in two stages");

    a_irq_event_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R2]
        |(rise & s_q.irq_sel) |=> (s_q.status[17:0] & $past(rise & s_q.irq_sel))
            == $past(rise & s_q.irq_sel))
        else $error("line event lost from status");

    a_wake_exit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R2]
        (s_q.sleep && |(rise & s_q.wake_sel)) |=> !s_q.sleep && s_q.status[`WAKE_BIT])
        else $error("wake line did not end sleep");

    a_req_line_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R3]
        (s_q.req_en && !s_q.req_sel) |=> o_prog_io_oe[`REQ_LINE_A]
            && o_prog_io_line[`REQ_LINE_A] == !$past(s_q.sleep))
        else $error("clock request not on line 6");

    a_req_sleep_low: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R4]
        (s_q.req_en && s_q.req_sel && !s_q.or_en && s_q.sleep) ##1 (s_q.sleep && !s_q.or_en)
            |-> !o_prog_io_line[`REQ_LINE_B] && o_prog_io_oe[`REQ_LINE_B])
        else $error("clock request high in deep sleep");

    a_or_output: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R6]
        $rose(s_q.or_en) |=> o_prog_io_oe[`REQ_LINE_B] && !o_prog_io_oe[`HOST_EN_LINE])
        else $error("OR mode pin directions wrong");

    a_host_starts_clk: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R5]
        (s_q.or_en && s_q.sleep && i_prog_io_line[`HOST_EN_LINE])
            |-> o_prog_io_line[`REQ_LINE_B])
        else $error("host enable did not start clock");

    a_line2_float: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R8]
        !$past(s_q.configured) |-> !o_prog_io_oe[`REQ_LINE_B])
        else $error("line 2 driven before configuration");

    a_trim_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R9]
        (wr && i_paddr == `OFS_XTAL_TRIM) |=> o_crystal_trim_code == $past(i_pwdata[5:0]))
        else $error("trim code not stored");

    a_apin_legal: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R10]
        o_analogue_io_pin0_sel <= `APIN0_MAX && o_analogue_io_pin1_sel <= `APIN1_MAX)
        else $error("illegal analogue clock selection");

    a_apb_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
        else $error("APB answer not one cycle after access");

endmodule // clock_request_pio_control
